// ---- dual_reload_timers.sv ----
`timescale 1ns/1ps
`default_nettype none
module dual_reload_timers #(
    parameter int unsigned ADDR_WIDTH = 8
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  cyc_i,
    input  wire logic                  stb_i,
    input  wire logic                  we_i,
    input  wire logic [ADDR_WIDTH-1:0] adr_i,
    input  wire logic [3:0]            sel_i,
    input  wire logic [31:0]           dat_i,
    output logic      [31:0]           dat_o,
    output logic                       ack_o,
    input  wire logic                  ext_count_pin_i,
    output logic                       timer0_irq_o,
    output logic                       timer1_irq_o
);

    // Bus handshake state
    logic              ack;          // Registered acknowledge
    logic [31:0]       rdata;        // Registered read data
    // Timer state, element 0 is timer0, element 1 is timer1
    logic [7:0]        count    [2]; // Running counts
    logic [7:0]        reload   [2]; // Restart values
    logic [7:0]        prescale [2]; // Internal prescaler counters
    dual_reload_timers_pkg::timer_ctrl_type ctrl [2]; // Control fields
    logic [1:0]        pending;      // Overflow flags
    logic [1:0]        irq_en;       // Interrupt enables
    logic [1:0]        step;         // Count advances this cycle
    logic [1:0]        wrap;         // Count wraps this cycle
    logic [1:0]        next_pending; // Flags after this cycle
    // Instruction clock and pin synchroniser
    logic              inst_tick;    // High every other clock
    logic              pin_meta;     // First synchroniser stage
    logic              pin_sync;     // Second synchroniser stage
    logic              pin_prev;     // Previous synchronised level
    logic              pin_edge;     // Selected edge seen

    // Decoded bus fields
    logic [5:0] idx;
    logic       wr_strobe;
    logic [7:0] wbyte;

    assign idx       = adr_i[7:2];
    // Writes land on the edge where the master samples ack high
    assign wr_strobe = cyc_i & stb_i & we_i & ack & sel_i[0];
    assign wbyte     = dat_i[7:0];

    // True when this cycle writes the register at index target
    function automatic logic write_hit(input logic [5:0] target);
        return wr_strobe && (idx == target);
    endfunction : write_hit

    // Prescaler mask: ratio minus one, 1xxx means full 256
    function automatic logic [7:0] divider_mask(input logic [3:0] code);
        logic [3:0] shift;
        shift = dual_reload_timers_pkg::DIV_SHIFT - {1'b0, code[2:0]};
        if (code[3]) begin
            return 8'hFF;
        end
        return 8'hFF >> shift;
    endfunction : divider_mask

    // Single-wait-state slave: ack one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
        end else begin
            ack <= cyc_i & stb_i & ~ack;
        end
    end

    // Read data captured together with ack; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata <= 32'h0000_0000;
        end else if (cyc_i & stb_i & ~ack) begin
            rdata <= 32'h0000_0000;
            unique case (idx)
                dual_reload_timers_pkg::IDX_TIMER0_COUNT: begin
                    rdata[7:0] <= count[0];
                end
                dual_reload_timers_pkg::IDX_TIMER1_COUNT: begin
                    rdata[7:0] <= count[1];
                end
                dual_reload_timers_pkg::IDX_TIMER0_RELOAD: begin
                    rdata[7:0] <= reload[0];
                end
                dual_reload_timers_pkg::IDX_TIMER1_RELOAD: begin
                    rdata[7:0] <= reload[1];
                end
                dual_reload_timers_pkg::IDX_TIMER0_CONTROL: begin
                    rdata[6:0] <= ctrl[0];
                end
                dual_reload_timers_pkg::IDX_TIMER1_CONTROL: begin
                    rdata[6:0] <= ctrl[1];
                end
                dual_reload_timers_pkg::IDX_IRQ_ENABLE: begin
                    rdata[5:4] <= irq_en;
                end
                dual_reload_timers_pkg::IDX_IRQ_FLAGS: begin
                    rdata[5:4] <= pending;
                end
                default: begin
                    rdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign ack_o = ack;
    assign dat_o = rdata;

    // Instruction clock: one enable pulse per two system clocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inst_tick <= 1'b0;
        end else begin
            inst_tick <= ~inst_tick;
        end
    end

    // Pin sampled at instruction rate; short pulses may be missed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end else if (inst_tick) begin
            pin_meta <= ext_count_pin_i;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Edge detector works on the second stage only
    always_comb begin
        if (ctrl[0].edge_falling) begin
            pin_edge = inst_tick & pin_prev & ~pin_sync;
        end else begin
            pin_edge = inst_tick & ~pin_prev & pin_sync;
        end
    end

    // One counter slice per timer; only timer0 may take the pin
    for (genvar i = 0; i < 2; i++) begin : g_timer
        localparam logic [5:0] CNT_IDX = (i == 0) ?
            dual_reload_timers_pkg::IDX_TIMER0_COUNT :
            dual_reload_timers_pkg::IDX_TIMER1_COUNT;
        localparam logic [5:0] RLD_IDX = (i == 0) ?
            dual_reload_timers_pkg::IDX_TIMER0_RELOAD :
            dual_reload_timers_pkg::IDX_TIMER1_RELOAD;
        localparam logic [5:0] CTL_IDX = (i == 0) ?
            dual_reload_timers_pkg::IDX_TIMER0_CONTROL :
            dual_reload_timers_pkg::IDX_TIMER1_CONTROL;

        logic       src_tick; // Prescaler input pulse
        logic [7:0] mask;     // Current divide mask

        // Timer1 is wired to the instruction clock alone
        if (i == 0) begin : g_src0
            assign src_tick = ctrl[0].source_pin ? pin_edge
                                                 : inst_tick;
        end else begin : g_src1
            assign src_tick = inst_tick;
        end

        assign mask    = divider_mask(ctrl[i].divider);
        // Advance once per full prescaler period while running
        assign step[i] = src_tick & ~ctrl[i].halt &
                         ((prescale[i] & mask) == mask);
        assign wrap[i] = step[i] &
                         (count[i] == dual_reload_timers_pkg::COUNT_TOP);

        // Prescaler restarts on control or count write for a clean period
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                prescale[i] <= dual_reload_timers_pkg::RESET_BYTE;
            end else if (write_hit(CNT_IDX) || write_hit(CTL_IDX)) begin
                prescale[i] <= dual_reload_timers_pkg::RESET_BYTE;
            end else if (src_tick && !ctrl[i].halt) begin
                prescale[i] <= prescale[i] + 8'h01;
            end
        end

        // Count: software write beats a simultaneous advance
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                count[i] <= dual_reload_timers_pkg::RESET_BYTE;
            end else if (write_hit(CNT_IDX)) begin
                count[i] <= wbyte;
            end else if (wrap[i]) begin
                count[i] <= reload[i];
            end else if (step[i]) begin
                count[i] <= count[i] + 8'h01;
            end
        end

        // Reload register
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                reload[i] <= dual_reload_timers_pkg::RESET_BYTE;
            end else if (write_hit(RLD_IDX)) begin
                reload[i] <= wbyte;
            end
        end

        // Control register; timer1 keeps no edge or source bits
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                ctrl[i] <= dual_reload_timers_pkg::CTRL_RESET;
            end else if (write_hit(CTL_IDX)) begin
                ctrl[i].halt    <= wbyte[dual_reload_timers_pkg::HALT_BIT];
                ctrl[i].divider <= wbyte[3:0];
                if (i == 0) begin
                    ctrl[i].edge_falling <=
                        wbyte[dual_reload_timers_pkg::EDGE_BIT];
                    ctrl[i].source_pin   <=
                        wbyte[dual_reload_timers_pkg::SOURCE_BIT];
                end else begin
                    ctrl[i].edge_falling <= 1'b0;
                    ctrl[i].source_pin   <= 1'b0;
                end
            end
        end
    end

    // Flag update: zeros clear, ones keep, overflow always wins
    always_comb begin
        next_pending = pending | wrap;
        if (write_hit(dual_reload_timers_pkg::IDX_IRQ_FLAGS)) begin
            next_pending = (pending &
                {wbyte[dual_reload_timers_pkg::T1_FLAG_BIT],
                 wbyte[dual_reload_timers_pkg::T0_FLAG_BIT]})
                | wrap;
        end
    end

    // Pending flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending <= 2'h0;
        end else begin
            pending <= next_pending;
        end
    end

    // Interrupt enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_en <= 2'h0;
        end else if (write_hit(dual_reload_timers_pkg::IDX_IRQ_ENABLE)) begin
            irq_en <= {wbyte[dual_reload_timers_pkg::T1_FLAG_BIT],
                       wbyte[dual_reload_timers_pkg::T0_FLAG_BIT]};
        end
    end

    // Requests are levels held until the flag or the enable is cleared
    assign timer0_irq_o = irq_en[0] & pending[0];
    assign timer1_irq_o = irq_en[1] & pending[1];

    // Checks on the design's own behaviour
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Write hits as signals, so the checks see sampled values and
    // not whatever a function body would read after the edge
    logic hit_flags;  // Flag register written this cycle
    logic hit_t0_cnt; // Timer0 count written this cycle
    logic hit_t1_cnt; // Timer1 count written this cycle
    logic hit_t0_ctl; // Timer0 control written this cycle
    assign hit_flags  = write_hit(dual_reload_timers_pkg::IDX_IRQ_FLAGS);
    assign hit_t0_cnt = write_hit(dual_reload_timers_pkg::IDX_TIMER0_COUNT);
    assign hit_t1_cnt = write_hit(dual_reload_timers_pkg::IDX_TIMER1_COUNT);
    assign hit_t0_ctl = write_hit(dual_reload_timers_pkg::IDX_TIMER0_CONTROL);

    sequence s_flag_write(logic [7:0] v);
        hit_flags && (wbyte == v);
    endsequence

    sequence s_count_quiet;
        !hit_t0_cnt && !hit_t1_cnt;
    endsequence

    chk_t0_flag_set: assert property (
        wrap[0] |=> pending[0])
        else $error("timer0 wrap did not set its flag");

    chk_t0_flag_clear: assert property (
        s_flag_write(dual_reload_timers_pkg::CLEAR_T0) ##0 !wrap[0]
        |=> !pending[0] &&
            (pending[1] == ($past(pending[1]) | $past(wrap[1]))))
        else $error("EFh write misbehaved on flags");

    chk_t1_flag_set: assert property (
        wrap[1] |=> pending[1])
        else $error("timer1 wrap did not set its flag");

    chk_t1_flag_clear: assert property (
        s_flag_write(dual_reload_timers_pkg::CLEAR_T1) ##0 !wrap[1]
        |=> !pending[1] &&
            (pending[0] == ($past(pending[0]) | $past(wrap[0]))))
        else $error("DFh write misbehaved on flags");

    chk_halt_freeze: assert property (
        ctrl[0].halt && ctrl[1].halt ##0 s_count_quiet
        |=> $stable(count[0]) && $stable(count[1]))
        else $error("halted timer changed its count");

    chk_irq_follows: assert property (
        wrap[0] && irq_en[0] ##1 irq_en[0] |-> timer0_irq_o)
        else $error("enabled timer0 overflow raised no request");

    chk_reload_wrap: assert property (
        wrap[1] && !hit_t1_cnt
        |=> count[1] == $past(reload[1]))
        else $error("timer1 did not reload after wrap");

    chk_presc_clear: assert property (
        hit_t0_ctl || hit_t0_cnt
        |=> prescale[0] == 8'h00)
        else $error("timer0 prescaler not cleared on write");

    chk_div1_rate: assert property (
        !ctrl[1].halt && (ctrl[1].divider == 4'h0) && inst_tick
        |-> step[1] ##1 !step[1])
        else $error("divide-by-one timer1 missed an instruction tick");

    chk_pin_edge: assert property (
        pin_edge |-> inst_tick && (pin_sync != pin_prev))
        else $error("pin edge seen without a level change");

endmodule : dual_reload_timers
`default_nettype wire

// ---- dual_reload_timers_pkg.sv ----
// Functional notes
// - Timer0 overflow sets flag bit 4
// - Writing EFh clears only timer0 flag
// - Timer1 overflow sets flag bit 5
// - Writing DFh clears only timer1 flag
// - Halt bit 6 set freezes the count
// - Interrupt request equals enable AND pending
// - Timer0 source: pin or instruction clock
// - Edge select 0 counts rising pin edges
// - Edge select 1 counts falling pin edges
// - Divider 2^n for 0-7, 256 for 1xxx
// - Timer1 counts prescaled clock, reloads on wrap
// - Timer1 rate set by its divider only
// - Timer1 count readable and writable anytime
// - Overflow rate clk/2/ratio/(256-reload)
// - Timer0 reload loaded on each rollover
// - Timer1 reload supplies restart after overflow
// - Timer0 control/count write clears prescaler
// - Past FFh: take reload, set flag
// - Pin synchronised; levels exceed one cycle
`default_nettype none
package dual_reload_timers_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_TIMER0_COUNT   = 6'h01;
    localparam logic [5:0] IDX_IRQ_ENABLE     = 6'h0B;
    localparam logic [5:0] IDX_IRQ_FLAGS      = 6'h0C;
    localparam logic [5:0] IDX_TIMER0_RELOAD  = 6'h10;
    localparam logic [5:0] IDX_TIMER0_CONTROL = 6'h11;
    localparam logic [5:0] IDX_TIMER1_COUNT   = 6'h12;
    localparam logic [5:0] IDX_TIMER1_RELOAD  = 6'h13;
    localparam logic [5:0] IDX_TIMER1_CONTROL = 6'h14;

    // Field positions in control, enable and flag registers
    localparam int unsigned HALT_BIT     = 6;
    localparam int unsigned EDGE_BIT     = 5;
    localparam int unsigned SOURCE_BIT   = 4;
    localparam int unsigned T0_FLAG_BIT  = 4;
    localparam int unsigned T1_FLAG_BIT  = 5;

    // Values after reset and special constants
    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [7:0] COUNT_TOP    = 8'hFF;
    localparam logic [7:0] CLEAR_T0     = 8'hEF;
    localparam logic [7:0] CLEAR_T1     = 8'hDF;
    localparam logic [3:0] DIV_SHIFT    = 4'h8;

    // Control fields of one timer
    typedef struct packed {
        logic       halt;
        logic       edge_falling;
        logic       source_pin;
        logic [3:0] divider;
    } timer_ctrl_type;

    localparam timer_ctrl_type CTRL_RESET = '0;

endpackage : dual_reload_timers_pkg
`default_nettype wire

// ---- ext_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Slow pulse source on the external count pin
module ext_pin_model (
    input  wire logic clk_i,  // Bench clock, used to pace the levels
    output logic      pin_o   // Count pin level seen by the timer
);
    // Each level lasts over four instruction cycles so no edge can be missed
    localparam int HOLD_CLKS = 8;

    // Pin rests low until the bench asks for edges
    initial begin
        pin_o = 1'b0;
    end

    // Toggle the pin n times; an odd n leaves it at the other level
    task automatic toggle(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            pin_o <= ~pin_o;
            repeat (HOLD_CLKS) @(posedge clk_i);
        end
    endtask : toggle
endmodule : ext_pin_model
`default_nettype wire

// ---- dual_reload_timers_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module dual_reload_timers_tb_top;
    // One table row: register index, byte written, byte read back
    typedef struct packed {
        logic [5:0] idx;
        logic [7:0] wd;
        logic [7:0] exp;
    } row_type;
    // Short aliases keep the table readable
    localparam logic [5:0] T0N = dual_reload_timers_pkg::IDX_TIMER0_COUNT;
    localparam logic [5:0] IEN = dual_reload_timers_pkg::IDX_IRQ_ENABLE;
    localparam logic [5:0] IFL = dual_reload_timers_pkg::IDX_IRQ_FLAGS;
    localparam logic [5:0] T0R = dual_reload_timers_pkg::IDX_TIMER0_RELOAD;
    localparam logic [5:0] T0C = dual_reload_timers_pkg::IDX_TIMER0_CONTROL;
    localparam logic [5:0] T1N = dual_reload_timers_pkg::IDX_TIMER1_COUNT;
    localparam logic [5:0] T1R = dual_reload_timers_pkg::IDX_TIMER1_RELOAD;
    localparam logic [5:0] T1C = dual_reload_timers_pkg::IDX_TIMER1_CONTROL;
    // Both timers halted first, so counts read back as written
    localparam row_type ROWS [10] = '{
        '{T0C, 8'h40, 8'h40}, '{T1C, 8'h7F, 8'h4F},
        '{T0R, 8'hAA, 8'hAA}, '{T1R, 8'h55, 8'h55},
        '{T0N, 8'h3C, 8'h3C}, '{T1N, 8'hC3, 8'hC3},
        '{IEN, 8'hFF, 8'h30}, '{IFL, 8'hFF, 8'h00},
        '{IEN, 8'h00, 8'h00}, '{6'h3F, 8'h5A, 8'h00}
    };
    logic        clk_i, rst_i, cyc_i, stb_i, we_i;  // Clock, reset, bus
    logic [7:0]  adr_i;                             // Byte address
    logic [3:0]  sel_i;                             // Byte lanes
    logic [3:0]  lanes = 4'h1;                      // Lanes for next call
    logic [31:0] dat_i, dat_o;                      // Bus data
    logic        ack_o, ext_count_pin_i;            // Answer and pin
    logic        timer0_irq_o, timer1_irq_o;        // Requests
    logic [7:0]  rd;                                // Last read byte
    int          err_count, num_checks, cyc_n;      // Tallies, cycle count

    dual_reload_timers u_dual_reload_timers (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .ext_count_pin_i(ext_count_pin_i),
        .timer0_irq_o(timer0_irq_o), .timer1_irq_o(timer1_irq_o));
    ext_pin_model u_ext_pin_model (.clk_i(clk_i), .pin_o(ext_count_pin_i));

    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Free cycle counter used to time overflow periods
    always @(posedge clk_i) cyc_n <= cyc_n + 1;

    // Print the tallies and the verdict, then end the run
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    // Byte comparison with case equality so unknowns never match
    task automatic check_byte(input string nm, input logic [7:0] e, g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : check_byte
    // Cycle count comparison for measured periods
    task automatic check_count(input string nm, input int e, g);
        num_checks++;
        if (g != e) begin
            err_count++;
            $display("wrong value %s expected %0d seen %0d", nm, e, g);
        end
    endtask : check_count
    // One classic cycle; held until ack, released at that edge
    task automatic wb(input logic w, input logic [5:0] idx,
                      input logic [7:0] wd, output logic [7:0] rv);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= lanes;
        dat_i <= {24'h0, wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        rv = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 50) begin
            check_count("bus_ack_wait", 0, n);
            stop_test();
        end
    endtask : wb
    // Wait for a request line to reach a level; a hang ends the run
    task automatic wait_irq(input int t, input logic lvl, output int st);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((t ? timer1_irq_o : timer0_irq_o) !== lvl && n < 2000);
        st = cyc_n;
        if (n >= 2000) begin
            check_count("irq_wait", 0, n);
            stop_test();
        end
    endtask : wait_irq
    // Set up one timer, then time two overflows a period apart
    task automatic period(input int t, input logic [7:0] ctl, rld);
        int         ratio, s0, s1;
        logic [5:0] ci, ni;
        logic [7:0] clr;
        ci    = t ? T1C : T0C;
        ni    = t ? T1N : T0N;
        clr   = t ? 8'hDF : 8'hEF;
        ratio = ctl[3] ? 256 : (1 << ctl[2:0]);
        wb(1'b1, ci, ctl | 8'h40, rd);
        wb(1'b1, t ? T1R : T0R, rld, rd);
        wb(1'b1, ni, rld, rd);
        wb(1'b1, IFL, clr, rd);
        wb(1'b1, IEN, t ? 8'h20 : 8'h10, rd);
        wb(1'b1, ci, ctl, rd);
        wait_irq(t, 1'b1, s0);
        wb(1'b1, IFL, clr, rd);
        wait_irq(t, 1'b0, s1);
        wait_irq(t, 1'b1, s1);
        check_count("period", 2 * ratio * (256 - int'(rld)), s1 - s0);
    endtask : period
    // Count pin edges in pin mode and read the halted count
    task automatic pin_run(input logic [7:0] ctl);
        wb(1'b1, T0C, 8'h50, rd);
        wb(1'b1, T0N, 8'h00, rd);
        wb(1'b1, T0C, ctl, rd);
        u_ext_pin_model.toggle(7);
        repeat (12) @(posedge clk_i);
        wb(1'b1, T0C, 8'h50, rd);
        wb(1'b0, T0N, 8'h00, rd);
    endtask : pin_run

    // Main sequence
    initial begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i  = 1'b0;
        adr_i = 8'h00;
        sel_i = 4'h0;
        dat_i = 32'h0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // Table: write, read back, compare
        foreach (ROWS[i]) begin
            wb(1'b1, ROWS[i].idx, ROWS[i].wd, rd);
            wb(1'b0, ROWS[i].idx, 8'h00, rd);
            check_byte("register", ROWS[i].exp, rd);
        end
        // A halted count must not move
        repeat (40) @(posedge clk_i);
        wb(1'b0, T1N, 8'h00, rd);
        check_byte("halted_count", 8'hC3, rd);
        // Overflow periods over dividers, reloads and both timers
        period(1, 8'h00, 8'hF8);
        period(1, 8'h03, 8'hFF);
        period(1, 8'h09, 8'hFF);
        period(0, 8'h01, 8'hFC);
        period(0, 8'h07, 8'hFF);
        // Both flags pending; enables gate the requests, clears are exact
        wb(1'b1, T0C, 8'h40, rd);
        wb(1'b1, T1C, 8'h40, rd);
        wb(1'b0, IFL, 8'h00, rd);
        check_byte("flags", 8'h30, rd);
        wb(1'b1, IEN, 8'h10, rd);
        repeat (2) @(posedge clk_i);
        check_byte("irq0", 8'h01, {7'h0, timer0_irq_o});
        check_byte("irq1", 8'h00, {7'h0, timer1_irq_o});
        wb(1'b1, IFL, 8'hEF, rd);
        wb(1'b0, IFL, 8'h00, rd);
        check_byte("flags", 8'h20, rd);
        wb(1'b1, IEN, 8'h30, rd);
        repeat (2) @(posedge clk_i);
        check_byte("irq0", 8'h00, {7'h0, timer0_irq_o});
        check_byte("irq1", 8'h01, {7'h0, timer1_irq_o});
        wb(1'b1, IFL, 8'hDF, rd);
        wb(1'b0, IFL, 8'h00, rd);
        check_byte("flags", 8'h00, rd);
        // A write with lane 0 off is acked but changes nothing
        lanes = 4'h0;
        wb(1'b1, T1R, 8'hA5, rd);
        lanes = 4'h1;
        wb(1'b0, T1R, 8'h00, rd);
        check_byte("lane_off_write", 8'hFF, rd);
        // Seven toggles: four edges of the chosen kind, three of the other
        pin_run(8'h10);
        check_byte("rising_count", 8'h04, rd);
        pin_run(8'h30);
        check_byte("falling_count", 8'h04, rd);
        // Mid-run reset; counts are left out as they run straight after
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i != 4 && i != 5) begin
                wb(1'b0, ROWS[i].idx, 8'h00, rd);
                check_byte("reset_value", 8'h00, rd);
            end
        end
        stop_test();
    end
endmodule : dual_reload_timers_tb_top
`default_nettype wire
